//--- design/mp_consts.svh
`ifndef MP_CONSTS_SVH
`define MP_CONSTS_SVH
// Register offsets
`define MODE_BASE 16'hf510
`define WRITE_BASE 16'hf520
`define READ_BASE 16'hf530
`define MIC_CTRL0 16'hf560
`define MIC_CTRL1 16'hf561
// Pin count
`define NUM_PINS 14
// Pin function select fields
`define MODE_DEB_BIT 3
`define MODE_RST 4'h8
// Microphone control fields
`define MIC_EN_BIT 0
`define MIC_PIN_LSB 4
`define MIC_SRC_LSB 8
`define MIC_OK_BIT 15
`define MIC_WMASK 16'h07f1
`define MIC_RST 16'h0000
// Clock rates in Hz
`define CLK_HZ 125000000
`define MIC_CLK_MIN_HZ 1000000
`define MIC_CLK_MAX_HZ 3300000
// Bit clock period limits in system cycles
`define MIC_PER_MAX (`CLK_HZ / `MIC_CLK_MIN_HZ)
`define MIC_PER_MIN ((`CLK_HZ + `MIC_CLK_MAX_HZ - 1) / `MIC_CLK_MAX_HZ)
// Debounce hold and decimation ratio
`define DEB_CYC 16
`define DECIM 64
`endif

//--- design/mp_pkg.sv
package mp_pkg;
  // Pin function encodings, in register order
  typedef enum logic [2:0] {
    MODE_HW_IN,
    MODE_SW_IN,
    MODE_OUT_PU,
    MODE_OUT,
    MODE_MIC,
    MODE_PANIC,
    MODE_SPI_SS
  } pin_mode_e;
  typedef logic [15:0] reg_word_t;
endpackage : mp_pkg

//--- design/multipurpose_pins.sv
// What this block does
// - Up to four microphone channels, two per shared data pin.
// - Any pin may carry one microphone pair, set by mode and mic control.
// - Mic clock is one selected master serial port bit clock.
// - Bit clock period checked against the 1 MHz to 3.3 MHz band.
// - Mic bitstreams are decimated and offered as sample words.
// - Fourteen multipurpose pins usable as general-purpose I/O.
// - Mode field picks one of seven pin functions.
// - Software input mode takes the value written by the host.
// - Hardware input mode has an optional debounce filter.
// - GPIO state changes only on the per-sample tick.
// - Program input per pin, flagged valid only in input modes.
// - Program value drives a pin only in output mode.
`timescale 1ns/1ps
`include "mp_consts.svh"
module multipurpose_pins #(
  parameter int NP = `NUM_PINS,
  parameter int DEB = `DEB_CYC,
  parameter int DECIM = `DECIM,
  parameter int PW = $clog2(DECIM) + 1
) (
  input logic clk_sys,
  input logic rst,
  input logic [15:0] reg_addr,
  input mp_pkg::reg_word_t reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output mp_pkg::reg_word_t reg_rdata,
  input logic [NP-1:0] pin_in,
  output logic [NP-1:0] pin_out,
  output logic [NP-1:0] pin_oe,
  output logic [NP-1:0] pin_pullup,
  input logic [3:0] input_port_bit_clock,
  input logic [3:0] output_port_bit_clock,
  input logic sample_tick,
  input logic [NP-1:0] prog_out,
  input logic panic_flag,
  input logic spi_ss_n,
  output logic [NP-1:0] prog_in,
  output logic [NP-1:0] prog_in_valid,
  output logic [3:0][PW-1:0] pcm_data,
  output logic [3:0] pcm_valid
);
  import mp_pkg::*;

  localparam int NS = NP + 8;
  localparam int DW = $clog2(DEB + 1);
  localparam int BW = $clog2(DECIM);
  localparam int RW = $clog2(`MIC_PER_MAX + 2);
  localparam logic [3:0] NP4 = 4'(NP);
  localparam logic [11:0] MODE_HI = 12'(`MODE_BASE >> 4);
  localparam logic [11:0] WR_HI = 12'(`WRITE_BASE >> 4);
  localparam logic [11:0] RD_HI = 12'(`READ_BASE >> 4);
  localparam logic [RW-1:0] PMAX = RW'(`MIC_PER_MAX);
  localparam logic [RW-1:0] PMIN = RW'(`MIC_PER_MIN);
  // Three-stage sampling of pins and bit clocks
  logic [NS-1:0] s1, s2, s3, filt, next_filt;
  always_comb begin
    next_filt = (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else begin
      s1 <= {output_port_bit_clock, input_port_bit_clock, pin_in};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end
  // Register file
  logic [3:0] mode [NP], next_mode [NP];
  logic [NP-1:0] sw_val, next_sw;
  reg_word_t mic_ctrl [2], next_mic [2], next_rdata;
  logic [1:0] mic_ok;
  logic [3:0] idx;
  logic hit;
  always_comb begin
    next_mode = mode;
    next_sw = sw_val;
    next_mic = mic_ctrl;
    next_rdata = reg_rdata;
    idx = reg_addr[3:0];
    hit = idx < NP4;
    if (reg_wr) begin
      if (reg_addr[15:4] == MODE_HI && hit) begin
        next_mode[idx] = reg_wdata[3:0];
      end
      if (reg_addr[15:4] == WR_HI && hit) begin
        next_sw[idx] = reg_wdata[0];
      end
      if (reg_addr == `MIC_CTRL0) begin
        next_mic[0] = reg_wdata & `MIC_WMASK;
      end
      if (reg_addr == `MIC_CTRL1) begin
        next_mic[1] = reg_wdata & `MIC_WMASK;
      end
    end
    if (reg_rd) begin
      next_rdata = 16'h0000;
      if (reg_addr[15:4] == MODE_HI && hit) begin
        next_rdata = {12'h000, mode[idx]};
      end
      if (reg_addr[15:4] == WR_HI && hit) begin
        next_rdata = {15'h0000, sw_val[idx]};
      end
      if (reg_addr[15:4] == RD_HI && hit) begin
        next_rdata = {15'h0000, prog_in[idx]};
      end
      if (reg_addr == `MIC_CTRL0) begin
        next_rdata = mic_ctrl[0];
        next_rdata[`MIC_OK_BIT] = mic_ok[0];
      end
      if (reg_addr == `MIC_CTRL1) begin
        next_rdata = mic_ctrl[1];
        next_rdata[`MIC_OK_BIT] = mic_ok[1];
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= '{default: `MODE_RST};
      sw_val <= '0;
      mic_ctrl <= '{default: `MIC_RST};
      reg_rdata <= 16'h0000;
    end else begin
      mode <= next_mode;
      sw_val <= next_sw;
      mic_ctrl <= next_mic;
      reg_rdata <= next_rdata;
    end
  end
  // Per-pin function decode
  logic [NP-1:0] sw_mask, in_mask, gpio_mask, oe_mask, pu_mask, mic_mask;
  logic [NP-1:0] deb_en;
  pin_mode_e m;
  always_comb begin
    m = MODE_HW_IN;
    for (int i = 0; i < NP; i++) begin
      m = pin_mode_e'(mode[i][2:0]);
      sw_mask[i] = m == MODE_SW_IN;
      in_mask[i] = m == MODE_HW_IN || m == MODE_SW_IN;
      gpio_mask[i] = m == MODE_OUT_PU || m == MODE_OUT;
      oe_mask[i] = gpio_mask[i] || m == MODE_PANIC || m == MODE_SPI_SS;
      pu_mask[i] = m == MODE_OUT_PU;
      mic_mask[i] = m == MODE_MIC;
      deb_en[i] = mode[i][`MODE_DEB_BIT];
    end
  end
  // Debounce, program inputs and pin drivers
  logic [NP-1:0] deb, next_deb, next_in, next_valid;
  logic [NP-1:0] next_out, next_oe, next_pu;
  logic [DW-1:0] cnt [NP], next_cnt [NP];
  always_comb begin
    next_deb = deb;
    next_cnt = cnt;
    next_in = prog_in;
    next_valid = prog_in_valid;
    next_out = pin_out;
    next_oe = oe_mask;
    next_pu = pu_mask;
    for (int i = 0; i < NP; i++) begin
      if (!deb_en[i] || filt[i] == deb[i]) begin
        next_cnt[i] = '0;
        next_deb[i] = filt[i];
      end else if (cnt[i] == DW'(DEB - 1)) begin
        next_cnt[i] = '0;
        next_deb[i] = filt[i];
      end else begin
        next_cnt[i] = cnt[i] + 1'b1;
      end
      if (sample_tick) begin
        next_in[i] = sw_mask[i] ? sw_val[i] : deb[i];
        next_valid[i] = in_mask[i];
        if (gpio_mask[i]) begin
          next_out[i] = prog_out[i];
        end
      end
      if (pin_mode_e'(mode[i][2:0]) == MODE_PANIC) begin
        next_out[i] = panic_flag;
      end
      if (pin_mode_e'(mode[i][2:0]) == MODE_SPI_SS) begin
        next_out[i] = spi_ss_n;
      end
      if (!oe_mask[i]) begin
        next_out[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      deb <= '0;
      cnt <= '{default: '0};
      prog_in <= '0;
      prog_in_valid <= '0;
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup <= '0;
    end else begin
      deb <= next_deb;
      cnt <= next_cnt;
      prog_in <= next_in;
      prog_in_valid <= next_valid;
      pin_out <= next_out;
      pin_oe <= next_oe;
      pin_pullup <= next_pu;
    end
  end
  // Microphone pair capture and bit clock check
  logic [7:0] ck, ckq;
  logic [1:0] act, rise, next_ok;
  logic [3:0] stb, bitv, dpin;
  logic [2:0] src;
  logic [RW-1:0] per [2], next_per [2];
  always_comb begin
    ck = filt[NP+:8];
    next_per = per;
    next_ok = mic_ok;
    for (int p = 0; p < 2; p++) begin
      src = mic_ctrl[p][`MIC_SRC_LSB+:3];
      dpin = mic_ctrl[p][`MIC_PIN_LSB+:4];
      act[p] = mic_ctrl[p][`MIC_EN_BIT] && dpin < NP4 && mic_mask[dpin];
      rise[p] = ck[src] && !ckq[src];
      stb[2*p] = act[p] && rise[p];
      stb[2*p+1] = act[p] && !ck[src] && ckq[src];
      bitv[2*p] = (dpin < NP4) ? filt[dpin] : 1'b0;
      bitv[2*p+1] = bitv[2*p];
      if (rise[p]) begin
        next_ok[p] = per[p] >= PMIN && per[p] <= PMAX;
        next_per[p] = RW'(1);
      end else if (per[p] > PMAX) begin
        next_ok[p] = 1'b0;
      end else begin
        next_per[p] = per[p] + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ckq <= '0;
      per <= '{default: '0};
      mic_ok <= '0;
    end else begin
      ckq <= ck;
      per <= next_per;
      mic_ok <= next_ok;
    end
  end
  // Boxcar decimation, one channel per microphone
  logic [PW-1:0] ones [4], next_ones [4];
  logic [BW-1:0] bc [4], next_bc [4];
  logic [3:0][PW-1:0] next_pcm;
  logic [3:0] next_pv;
  always_comb begin
    next_ones = ones;
    next_bc = bc;
    next_pcm = pcm_data;
    next_pv = '0;
    for (int c = 0; c < 4; c++) begin
      if (!act[c/2]) begin
        next_ones[c] = '0;
        next_bc[c] = '0;
      end else if (stb[c]) begin
        if (bc[c] == BW'(DECIM - 1)) begin
          next_pcm[c] = ones[c] + PW'(bitv[c]);
          next_pv[c] = 1'b1;
          next_ones[c] = '0;
          next_bc[c] = '0;
        end else begin
          next_ones[c] = ones[c] + PW'(bitv[c]);
          next_bc[c] = bc[c] + 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ones <= '{default: '0};
      bc <= '{default: '0};
      pcm_data <= '0;
      pcm_valid <= '0;
    end else begin
      ones <= next_ones;
      bc <= next_bc;
      pcm_data <= next_pcm;
      pcm_valid <= next_pv;
    end
  end
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_in_hold: assert property (!sample_tick |=> $stable(prog_in))
    else $error("program input changed off tick");
  chk_gpio_once: assert property (
    !sample_tick |=> ((pin_out ^ $past(pin_out)) & gpio_mask
      & $past(gpio_mask)) == '0)
    else $error("gpio output changed off tick");
  chk_sw_input: assert property (
    sample_tick |=> ((prog_in ^ $past(sw_val)) & $past(sw_mask)) == '0)
    else $error("software input not taken");
  chk_in_valid: assert property (
    sample_tick |=> prog_in_valid == $past(in_mask))
    else $error("input valid flag wrong");
  chk_no_drive: assert property ((pin_oe & ~$past(oe_mask)) == '0)
    else $error("pin driven outside output mode");
  chk_pullup: assert property ((pin_pullup & ~pin_oe) == '0)
    else $error("pull-up without output");
  chk_deb_hold: assert property (
    (deb & ~$past(deb) & $past(deb_en) & ~$past(filt[NP-1:0], 8)) == '0)
    else $error("debounce let a glitch through");
  chk_pcm_range: assert property (
    pcm_valid[0] |-> pcm_data[0] <= PW'(DECIM))
    else $error("decimated word out of range");
  chk_pcm_space: assert property (pcm_valid[1] |=> !pcm_valid[1] [*8])
    else $error("decimated words too close");
  chk_mic_mode: assert property (
    stb[0] |-> mic_mask[mic_ctrl[0][`MIC_PIN_LSB+:4]])
    else $error("mic bit taken from non-mic pin");
  chk_mic_edges: assert property (stb[0] |-> !stb[1] ##1 !stb[0])
    else $error("both mic edges in one cycle");
  chk_clk_lost: assert property (per[0] > PMAX |=> !mic_ok[0])
    else $error("slow bit clock still reported good");
  cov_rise_word: cover property (pcm_valid[0]);
  cov_fall_word: cover property (pcm_valid[1]);
  cov_sw_tick: cover property (sample_tick && sw_mask != '0);
  cov_clk_ok: cover property ($rose(mic_ok[0]));
endmodule : multipurpose_pins

//--- tb/mic_pair_model.sv
`timescale 1ns/1ps
// Two microphones sharing one data line, clocked by the bit clock
module mic_pair_model (
  input wire logic bclk,
  input wire logic on,
  input wire logic [7:0] pat_rise,
  input wire logic [7:0] pat_fall,
  output logic data
);
  logic [2:0] idx_r;
  logic [2:0] idx_f;
  logic bit_q;
  initial begin
    idx_r = 3'h0;
    idx_f = 3'h0;
    bit_q = 1'b0;
  end
  // First mic drives after the falling edge, held over the rising edge
  always @(negedge bclk) begin
    bit_q <= #20 pat_rise[idx_r];
    idx_r <= idx_r + 3'h1;
  end
  // Second mic drives after the rising edge, held over the falling edge
  always @(posedge bclk) begin
    bit_q <= #20 pat_fall[idx_f];
    idx_f <= idx_f + 3'h1;
  end
  // Released line shows the inverse rather than a stale level
  assign data = on ? bit_q : ~bit_q;
endmodule : mic_pair_model

//--- tb/tb.sv
`timescale 1ns/1ps
`include "mp_consts.svh"
module tb;
  import mp_pkg::*;
  logic clk_sys, rst, reg_wr, reg_rd, sample_tick, panic_flag, spi_ss_n;
  logic [15:0] reg_addr;
  reg_word_t reg_wdata, reg_rdata, rv;
  logic [13:0] pin_drv, pin_in, pin_out, pin_oe, pin_pullup;
  logic [13:0] prog_out, prog_in, prog_in_valid;
  logic [3:0][3:0] pcm_data;
  logic [3:0] pcm_valid;
  logic bclk, bclk_run, mic_on, mic0_data, mic1_data;
  logic [3:0] in_bck, out_bck;
  logic [7:0] pat [4] = '{8'hff, 8'h55, 8'h11, 8'h07};
  int failures, total_checks;
  int got [4];
  logic [15:0] mtab [6] = '{16'h3, 16'h2, 16'h8, 16'h1, 16'h5, 16'h6};
  logic [3:0] pexp [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
  // Mic pairs sit on pins 6 and 7
  assign pin_in = {pin_drv[13:8], mic1_data, mic0_data, pin_drv[5:0]};
  // Port 1 of each direction carries the mic clock, port 0 its inverse
  assign in_bck = {2'b00, bclk, ~bclk};
  assign out_bck = {2'b00, bclk, ~bclk};
  multipurpose_pins #(.NP(14), .DEB(16), .DECIM(8), .PW(4)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .input_port_bit_clock(in_bck),
    .output_port_bit_clock(out_bck),
    .sample_tick(sample_tick), .prog_out(prog_out),
    .panic_flag(panic_flag), .spi_ss_n(spi_ss_n), .prog_in(prog_in),
    .prog_in_valid(prog_in_valid), .pcm_data(pcm_data),
    .pcm_valid(pcm_valid)
  );
  mic_pair_model mic0_u (.bclk(bclk), .on(mic_on), .pat_rise(pat[0]),
    .pat_fall(pat[1]), .data(mic0_data));
  mic_pair_model mic1_u (.bclk(bclk), .on(mic_on), .pat_rise(pat[2]),
    .pat_fall(pat[3]), .data(mic1_data));
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Bit clock, still outside streaming
  initial begin
    bclk = 1'b0;
    #3.3;
    forever #62.5 bclk = bclk_run ? ~bclk : 1'b0;
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic reg_write(input logic [15:0] a, input reg_word_t d);
    step(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [15:0] a, output reg_word_t d);
    step(1);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    d = reg_rdata;
  endtask : reg_read
  task automatic tick;
    step(1);
    sample_tick = 1'b1;
    step(1);
    sample_tick = 1'b0;
    step(1);
  endtask : tick
  task automatic test_done;
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, sample_tick, panic_flag, bclk_run, mic_on} = 6'h00;
    spi_ss_n = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    pin_drv = 14'h0000;
    prog_out = 14'h0000;
    failures = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    // Reset values, unmapped index, write mask
    reg_read(`MODE_BASE, rv); chk("mode rst", rv, `MODE_RST);
    reg_read(`MIC_CTRL0, rv); chk("mic rst", rv, `MIC_RST);
    reg_read(16'hf51e, rv); chk("unmapped", rv, 16'h0000);
    reg_write(`MIC_CTRL1, 16'hffff);
    reg_read(`MIC_CTRL1, rv); chk("mic mask", rv, `MIC_WMASK);
    // Six pin functions plus a host-written input value
    foreach (mtab[i]) reg_write(`MODE_BASE + 16'(i), mtab[i]);
    reg_write(`WRITE_BASE + 16'h3, 16'h0001);
    prog_out = 14'h3fff;
    panic_flag = 1'b1;
    spi_ss_n = 1'b0;
    tick();
    chk("oe", 16'(pin_oe), 16'h0033);
    chk("pullup", 16'(pin_pullup), 16'h0002);
    chk("out", 16'(pin_out), 16'h0013);
    chk("valid", 16'(prog_in_valid), 16'h3fcc);
    chk("sw in", 16'(prog_in & 14'h003f), 16'h0008);
    // GPIO outputs hold between ticks; panic and select pins follow their inputs at once
    prog_out = 14'h0000;
    panic_flag = 1'b0;
    spi_ss_n = 1'b1;
    step(5);
    chk("hold", 16'(pin_out), 16'h0023);
    tick();
    chk("update", 16'(pin_out), 16'h0020);
    // Debounce rejects a short glitch, passes a steady level
    pin_drv[2] = 1'b1;
    step(5);
    pin_drv[2] = 1'b0;
    step(30);
    tick();
    chk("glitch", 16'(prog_in[2]), 16'h0000);
    pin_drv[2] = 1'b1;
    step(30);
    tick();
    chk("steady", 16'(prog_in[2]), 16'h0001);
    reg_read(`READ_BASE + 16'h2, rv); chk("rd hw", rv, 16'h0001);
    reg_read(`READ_BASE + 16'h3, rv); chk("rd sw", rv, 16'h0001);
    // Two mic pairs, one per port clock domain
    reg_write(`MODE_BASE + 16'h6, 16'h0004);
    reg_write(`MODE_BASE + 16'h7, 16'h0004);
    bclk_run = 1'b1;
    mic_on = 1'b1;
    step(40);
    reg_write(`MIC_CTRL0, 16'h0161);
    reg_write(`MIC_CTRL1, 16'h0571);
    got = '{default: 0};
    for (int c = 0; c < 1000 && (got[0] < 2 || got[1] < 2 ||
        got[2] < 2 || got[3] < 2); c++) begin
      step(1);
      for (int k = 0; k < 4; k++) begin
        if (pcm_valid[k] === 1'b1) begin
          got[k]++;
          if (got[k] == 2) chk("pcm", 16'(pcm_data[k]), 16'(pexp[k]));
        end
      end
    end
    if (got[0] < 2 || got[1] < 2 || got[2] < 2 || got[3] < 2) begin
      failures++;
    end
    // An 8 MHz bit clock lies outside the mic band
    reg_read(`MIC_CTRL0, rv); chk("clk band", rv, 16'h0161);
    bclk_run = 1'b0;
    mic_on = 1'b0;
    // Reset in mid-run returns pins and registers to their idle state
    rst = 1'b1;
    step(2);
    chk("oe in rst", 16'(pin_oe), 16'h0000);
    chk("out in rst", 16'(pin_out), 16'h0000);
    rst = 1'b0;
    reg_read(`MODE_BASE + 16'h6, rv); chk("mode rst2", rv, `MODE_RST);
    reg_read(`MIC_CTRL0, rv); chk("mic rst2", rv, `MIC_RST);
    test_done();
  end
endmodule : tb
